/* flash_prot_dev.sv */
`timescale 1ns/100ps
module flash_prot_dev #(
  parameter int NUM_SECTORS = prot_pkg::NUM_SECTORS_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  spi_link_if.device link,
  input wire logic [NUM_SECTORS-1:0] range_prot,
  output logic [NUM_SECTORS-1:0] sector_prot,
  output logic key_mode,
  output logic persist_mode
);
  import prot_pkg::*;

  localparam int SW = $clog2(NUM_SECTORS);

  // the sector byte is eight bits, so more sectors cannot be addressed
  if (NUM_SECTORS < 2 || NUM_SECTORS > 256) begin : g_bad_sectors
    $error("NUM_SECTORS must be 2..256");
  end

  // ----------------------------------------
  // pin capture and edge finding
  // ----------------------------------------
  logic [2:0] pin_s; // synced sclk, select (inverted cs_n), mosi
  logic sclk_d_ff; // last synced sclk
  logic cs_d_ff; // last synced cs_n

  pin_sync #(.W(3)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    // select synced active high so the reset value reads as idle
    .din({link.sclk, ~link.cs_n, link.mosi}),
    .dout(pin_s)
  );

  wire sclk_s = pin_s[2];
  wire cs_s = ~pin_s[1]; // high while no frame is open
  wire mosi_s = pin_s[0];
  wire rise = sclk_s & ~sclk_d_ff & ~cs_s; // sample edge
  wire fall = ~sclk_s & sclk_d_ff & ~cs_s; // launch edge
  wire frame_end = cs_s & ~cs_d_ff;

  // ----------------------------------------
  // frame state
  // ----------------------------------------
  logic [2:0] bit_ff; // bit within byte
  logic [6:0] rx_ff; // partial byte
  logic [3:0] idx_ff; // byte number in frame, saturates
  logic [7:0] op_ff; // opcode of frame
  logic [7:0] sec_ff; // sector number of frame
  logic [7:0] tx_ff; // outgoing byte
  logic miso_ff; // driven data bit

  // ----------------------------------------
  // protection state
  // ----------------------------------------
  logic [15:0] cfg_ff; // protection_config_word
  logic [63:0] key_ff; // hidden_key
  logic lock_ff; // nv_bit_array_lock
  logic latch_ff; // write latch
  logic init_ff; // lock bit still to be set up
  logic [NUM_SECTORS-1:0] nv_ff; // nv_sector_protect_bit, 1 = erased
  logic [NUM_SECTORS-1:0] vol_ff; // volatile_sector_protect_bit

  // ----------------------------------------
  // decode of the byte just completed
  // ----------------------------------------
  wire [7:0] rx_byte = {rx_ff, mosi_s};
  wire byte_done = rise & (bit_ff == 3'd7);
  wire [7:0] cur_op = (idx_ff == 4'd0) ? rx_byte : op_ff;
  wire [7:0] cur_sec = (idx_ff == 4'd1) ? rx_byte : sec_ff;
  wire sec_ok = int'(cur_sec) < NUM_SECTORS; // out of range sector is ignored
  wire [SW-1:0] sidx = cur_sec[SW-1:0];
  wire [3:0] didx = idx_ff - 4'd1; // data byte number for writes
  wire key_shown = cfg_ff[KEY_MODE_LOCK_BIT];

  // writes at the last bit of their byte; latch set and clear at frame end
  wire wr_cfg = byte_done & (op_ff == OP_PROG_CFG) & latch_ff
    & (idx_ff == 4'd1 || idx_ff == 4'd2);
  wire wr_key = byte_done & (op_ff == OP_PROG_KEY) & latch_ff
    & (idx_ff != 4'd0) & (idx_ff <= 4'd8);
  wire wr_lock = byte_done & (op_ff == OP_WR_LOCK) & (idx_ff == 4'd1);
  wire wr_nv = byte_done & (op_ff == OP_PROG_NV) & (idx_ff == 4'd1)
    & latch_ff & lock_ff & sec_ok;
  wire wr_vol = byte_done & (op_ff == OP_WR_VOL) & (idx_ff == 4'd2) & sec_ok;
  wire latch_set = frame_end & (op_ff == OP_LATCH) & (idx_ff == 4'd1);
  wire latch_clr = frame_end & ((op_ff == OP_PROG_CFG)
    | (op_ff == OP_PROG_KEY) | (op_ff == OP_PROG_NV));

  // ----------------------------------------
  // read data for the byte that follows
  // ----------------------------------------
  wire [7:0] cfg_rd = cfg_ff[8*idx_ff[0] +: 8];
  wire [7:0] key_rd = key_shown ? key_ff[8*idx_ff[2:0] +: 8] : KEY_HIDDEN;
  wire [7:0] nv_rd = (sec_ok && !nv_ff[sidx]) ? BIT_PROT : BIT_OPEN;
  wire [7:0] vol_rd = (sec_ok && !vol_ff[sidx]) ? BIT_PROT : BIT_OPEN;
  wire [7:0] tx_next =
    (cur_op == OP_RD_CFG && idx_ff < 4'd2) ? cfg_rd :
    (cur_op == OP_RD_KEY && idx_ff < 4'd8) ? key_rd :
    (cur_op == OP_RD_LOCK && idx_ff == 4'd0) ? {LOCK_RSVD_RST, lock_ff} :
    (cur_op == OP_RD_NV && idx_ff == 4'd1) ? nv_rd :
    (cur_op == OP_RD_VOL && idx_ff == 4'd1) ? vol_rd : 8'h00;

  assign link.miso = miso_ff;

  // ----------------------------------------
  // serial shifting: sample on rise, launch on fall
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      bit_ff <= 3'd0;
      rx_ff <= 7'h00;
      idx_ff <= 4'd0;
      op_ff <= 8'h00;
      sec_ff <= 8'h00;
      tx_ff <= 8'h00;
      miso_ff <= 1'b0;
    end else if (ce) begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_s;
      if (cs_s) begin
        // idle between frames, a cut frame is simply dropped
        bit_ff <= 3'd0;
        idx_ff <= 4'd0;
        tx_ff <= 8'h00;
        miso_ff <= 1'b0;
      end else if (rise) begin
        rx_ff <= rx_byte[6:0];
        bit_ff <= bit_ff + 3'd1;
        if (byte_done) begin
          if (idx_ff != 4'hF) begin
            idx_ff <= idx_ff + 4'd1;
          end
          if (idx_ff == 4'd0) begin
            op_ff <= rx_byte;
          end
          if (idx_ff == 4'd1) begin
            sec_ff <= rx_byte;
          end
          tx_ff <= tx_next;
        end
      end else if (fall) begin
        miso_ff <= tx_ff[7];
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // otp words: programming can only clear bits
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff <= CFG_DELIVERY;
      key_ff <= KEY_DELIVERY;
    end else if (ce) begin
      if (wr_cfg) begin
        cfg_ff[8*didx[0] +: 8] <= cfg_ff[8*didx[0] +: 8] & rx_byte;
      end
      if (wr_key) begin
        key_ff[8*didx[2:0] +: 8] <= key_ff[8*didx[2:0] +: 8] & rx_byte;
      end
    end
  end

  // ----------------------------------------
  // lock bit and write latch
  // ----------------------------------------
  // the lock bit cannot take the mode under async reset, so the first
  // enabled cycle after release loads it from the config word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_ff <= 1'b0;
      init_ff <= 1'b1;
      latch_ff <= 1'b0;
    end else if (ce) begin
      init_ff <= 1'b0;
      if (init_ff) begin
        lock_ff <= cfg_ff[KEY_MODE_LOCK_BIT];
      end else if (wr_lock) begin
        lock_ff <= lock_ff & rx_byte[0];
      end
      if (latch_set) begin
        latch_ff <= 1'b1;
      end else if (latch_clr) begin
        latch_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // per-sector bits and effective protection
  // ----------------------------------------
  for (genvar i = 0; i < NUM_SECTORS; i++) begin : g_sec
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        nv_ff[i] <= 1'b1;
        vol_ff[i] <= 1'b1;
        sector_prot[i] <= 1'b0;
      end else if (ce) begin
        if (wr_nv && sidx == SW'(i)) begin
          nv_ff[i] <= 1'b0;
        end
        // other data values leave the bit alone
        if (wr_vol && sidx == SW'(i) && rx_byte == BIT_PROT) begin
          vol_ff[i] <= 1'b0;
        end else if (wr_vol && sidx == SW'(i) && rx_byte == BIT_OPEN) begin
          vol_ff[i] <= 1'b1;
        end
        sector_prot[i] <= range_prot[i] | ~nv_ff[i] | ~vol_ff[i];
      end
    end
  end

  // ----------------------------------------
  // permanent mode indication
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_mode <= 1'b0;
      persist_mode <= 1'b0;
    end else if (ce) begin
      key_mode <= ~cfg_ff[KEY_MODE_LOCK_BIT];
      persist_mode <= ~cfg_ff[PERSIST_MODE_LOCK_BIT];
    end
  end
endmodule

/* flash_prot_host.sv */
`timescale 1ns/100ps
// register command controller driving the flash link
module flash_prot_host #(
  parameter int SCLK_HALF = prot_pkg::SCLK_HALF_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [prot_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [prot_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  spi_link_if.host link
);
  import prot_pkg::*;

  // device sync plus host sync need at least four cycles a half
  if (SCLK_HALF < 4 || SCLK_HALF > 256) begin : g_bad_half
    $error("SCLK_HALF must be 4..256");
  end

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOW = 2'b01,
    S_HIGH = 2'b11,
    S_END = 2'b10
  } link_state_t;

  // ----------------------------------------
  // strobe merge for byte lanes
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // registers and link state
  // ----------------------------------------
  logic aw_hold_ff, w_hold_ff; // captured write halves
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [11:0] ctrl_ff; // opcode and length
  logic [63:0] txd_ff; // bytes after opcode, low byte first
  logic [63:0] rxd_ff; // received bytes, last in low byte
  link_state_t st_ff;
  logic [7:0] div_ff; // half-period counter
  logic [2:0] bitc_ff; // bit in byte
  logic [3:0] bytec_ff; // bytes done, opcode included
  logic [7:0] sh_ff; // outgoing byte
  logic [6:0] rxb_ff; // incoming partial byte
  logic sclk_ff, cs_n_ff, mosi_ff;
  logic miso_s;

  pin_sync #(.W(1)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .din(link.miso),
    .dout(miso_s)
  );

  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = mosi_ff;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire aw_got = awvalid & awready;
  wire w_got = wvalid & wready;
  wire b_done = bvalid & bready;
  wire ar_got = arvalid & arready;
  wire r_done = rvalid & rready;
  wire commit = aw_hold_ff & w_hold_ff & ~bvalid;
  wire nxt_aw_hold = (aw_hold_ff | aw_got) & ~b_done;
  wire nxt_w_hold = (w_hold_ff | w_got) & ~b_done;
  wire nxt_rvalid = (rvalid | ar_got) & ~r_done;
  wire busy = st_ff != S_IDLE;
  wire wr_ctrl = commit & (awaddr_ff == ADDR_CTRL);
  wire wr_tlo = commit & (awaddr_ff == ADDR_TX_LO);
  wire wr_thi = commit & (awaddr_ff == ADDR_TX_HI);
  wire w_mapped = wr_ctrl | wr_tlo | wr_thi;
  wire [31:0] ctrl_new = merge({20'h0_0000, ctrl_ff}, wdata_ff, wstrb_ff);
  // go is ignored while busy or with an oversized length
  wire go = wr_ctrl & ctrl_new[CTRL_GO_BIT] & ~busy
    & (ctrl_new[CTRL_LEN_LSB +: 4] <= MAX_LEN);
  wire [31:0] rd_mux =
    (araddr == ADDR_CTRL) ? {20'h0_0000, ctrl_ff} :
    (araddr == ADDR_TX_LO) ? txd_ff[31:0] :
    (araddr == ADDR_TX_HI) ? txd_ff[63:32] :
    (araddr == ADDR_RX_LO) ? rxd_ff[31:0] :
    (araddr == ADDR_RX_HI) ? rxd_ff[63:32] :
    (araddr == ADDR_STAT) ? {31'h0000_0000, busy} : 32'h0000_0000;
  wire r_mapped = (araddr <= ADDR_STAT) & (araddr[1:0] == 2'b00);

  // ----------------------------------------
  // axi4-lite slave handshakes
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready <= ~nxt_aw_hold;
      wready <= ~nxt_w_hold;
      arready <= ~nxt_rvalid;
      rvalid <= nxt_rvalid;
      if (aw_got) begin
        awaddr_ff <= awaddr;
      end
      if (w_got) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (commit) begin
        bvalid <= 1'b1;
        bresp <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid <= 1'b0;
      end
      if (ar_got) begin
        rdata <= rd_mux;
        rresp <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // command registers
  // ----------------------------------------
  // writes to ctrl or tx while busy would corrupt the frame, so they drop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= 12'h000;
      txd_ff <= 64'h0000_0000_0000_0000;
    end else if (ce && !busy) begin
      if (wr_ctrl) begin
        ctrl_ff <= ctrl_new[11:0];
      end
      if (wr_tlo) begin
        txd_ff[31:0] <= merge(txd_ff[31:0], wdata_ff, wstrb_ff);
      end
      if (wr_thi) begin
        txd_ff[63:32] <= merge(txd_ff[63:32], wdata_ff, wstrb_ff);
      end
    end
  end

  // ----------------------------------------
  // link engine: mode 0, msb first
  // ----------------------------------------
  wire half_done = div_ff == 8'(SCLK_HALF - 1);
  wire [7:0] nxt_byte = txd_ff[8*bytec_ff[2:0] +: 8];
  wire [7:0] in_byte = {rxb_ff, miso_s};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= S_IDLE;
      div_ff <= 8'h00;
      bitc_ff <= 3'd0;
      bytec_ff <= 4'd0;
      sh_ff <= 8'h00;
      rxb_ff <= 7'h00;
      rxd_ff <= 64'h0000_0000_0000_0000;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
    end else if (ce) begin
      div_ff <= (st_ff == S_IDLE || half_done) ? 8'h00 : div_ff + 8'h01;
      unique case (st_ff)
        S_IDLE: begin
          if (go) begin
            cs_n_ff <= 1'b0;
            sh_ff <= ctrl_new[7:0];
            mosi_ff <= ctrl_new[7];
            bitc_ff <= 3'd0;
            bytec_ff <= 4'd0;
            rxd_ff <= 64'h0000_0000_0000_0000;
            st_ff <= S_LOW;
          end
        end
        S_LOW: begin
          if (half_done) begin
            sclk_ff <= 1'b1;
            st_ff <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (half_done) begin
            // miso is sampled late in the high half to cover sync delay
            sclk_ff <= 1'b0;
            rxb_ff <= in_byte[6:0];
            bitc_ff <= bitc_ff + 3'd1;
            st_ff <= S_LOW;
            if (bitc_ff == 3'd7) begin
              if (bytec_ff != 4'd0) begin
                rxd_ff <= {rxd_ff[55:0], in_byte};
              end
              if (bytec_ff == ctrl_ff[CTRL_LEN_LSB +: 4]) begin
                st_ff <= S_END;
              end else begin
                sh_ff <= nxt_byte;
                mosi_ff <= nxt_byte[7];
                bytec_ff <= bytec_ff + 4'd1;
              end
            end else begin
              sh_ff <= {sh_ff[6:0], 1'b0};
              mosi_ff <= sh_ff[6];
            end
          end
        end
        S_END: begin
          if (half_done) begin
            cs_n_ff <= 1'b1;
            mosi_ff <= 1'b0;
            st_ff <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule

/* pin_sync.sv */
`timescale 1ns/100ps
// two-stage synchroniser for pins from outside the clk domain
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff; // first stage, read only by dout
  // ----------------------------------------
  // two flops, frozen while ce is low
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      dout <= '0;
    end else if (ce) begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule

/* prot_checker.sv */
`timescale 1ns/100ps
// watches the serial link between the two ends
module prot_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_d_ff; // last sampled serial clock
  logic [2:0] rise_cnt_ff; // rises in frame, modulo one byte
  logic [2:0] nxt_rise_cnt;
  logic sclk_rise; // rising serial edge seen this cycle
  assign sclk_rise = sclk & ~sclk_d_ff;
  // count restarts whenever no frame is open
  assign nxt_rise_cnt = cs_n ? 3'h0 : rise_cnt_ff + {2'h0, sclk_rise};
  // short history only, so the counter stays cheap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_ff <= 1'h0;
      rise_cnt_ff <= 3'h0;
    end else begin
      sclk_d_ff <= sclk;
      rise_cnt_ff <= nxt_rise_cnt;
    end
  end
  // ----
  // link properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_IDLE_LOW: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  AST_MOSI_HOLD: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved in a high half");
  AST_MISO_HOLD: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("device data moved in a high half");
  AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("high half length wrong");
  AST_LOW_HALF: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("low half too short");
  AST_FIRST_EDGE: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
    else $error("first rise not one half after select");
  AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> rise_cnt_ff == 3'h0)
    else $error("frame ended inside a byte");
  AST_CLOSE_GAP: assert property ($rose(cs_n) |-> !$past(sclk) && !$past(sclk, 8))
    else $error("select released too soon after last bit");
endmodule

/* prot_pkg.sv */
package prot_pkg;
  // ----------------------------------------
  // device command opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_RD_CFG = 8'h2B;   // read_config_word_cmd
  localparam logic [7:0] OP_PROG_CFG = 8'h2F; // program_config_word_cmd
  localparam logic [7:0] OP_RD_KEY = 8'hE7;   // read_key_cmd
  localparam logic [7:0] OP_PROG_KEY = 8'hE8; // program_key_cmd
  localparam logic [7:0] OP_RD_LOCK = 8'hA7;  // read_array_lock_cmd
  localparam logic [7:0] OP_WR_LOCK = 8'hA6;  // write_array_lock_cmd
  localparam logic [7:0] OP_RD_NV = 8'hE2;    // read_nv_sector_bit_cmd
  localparam logic [7:0] OP_PROG_NV = 8'hE4;  // program_nv_sector_bit_cmd
  localparam logic [7:0] OP_RD_VOL = 8'hE0;   // read_volatile_sector_bit_cmd
  localparam logic [7:0] OP_WR_VOL = 8'hE1;   // write_volatile_sector_bit_cmd
  localparam logic [7:0] OP_LATCH = 8'h06;    // write_latch_set_cmd
  // ----------------------------------------
  // field positions, values after reset and data codes
  // ----------------------------------------
  localparam int KEY_MODE_LOCK_BIT = 2;       // key_mode_lock in config word
  localparam int PERSIST_MODE_LOCK_BIT = 1;   // persistent_mode_lock
  localparam logic [15:0] CFG_DELIVERY = 16'hFFFF;
  localparam logic [63:0] KEY_DELIVERY = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [6:0] LOCK_RSVD_RST = 7'h00;
  localparam logic [7:0] BIT_PROT = 8'h00;    // sector protected
  localparam logic [7:0] BIT_OPEN = 8'hFF;    // sector unprotected
  localparam logic [7:0] KEY_HIDDEN = 8'hFF;  // what a hidden key reads as
  // ----------------------------------------
  // controller register map (axi4-lite)
  // ----------------------------------------
  localparam int AXI_AW = 5;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_TX_LO = 5'h04;
  localparam logic [4:0] ADDR_TX_HI = 5'h08;
  localparam logic [4:0] ADDR_RX_LO = 5'h0C;
  localparam logic [4:0] ADDR_RX_HI = 5'h10;
  localparam logic [4:0] ADDR_STAT = 5'h14;
  localparam int CTRL_LEN_LSB = 8;
  localparam int CTRL_GO_BIT = 31;
  localparam logic [3:0] MAX_LEN = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ----------------------------------------
  // cycle and sector counts
  // ----------------------------------------
  localparam int SCLK_HALF_DEF = 8;           // clk cycles per serial clock half
  localparam int NUM_SECTORS_DEF = 16;
endpackage

/* sector_protection_registers_tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module sector_protection_registers_tb_top;
  import prot_pkg::*;
  logic clk, sys_rst, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, key_mode, persist_mode;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rx_lo, rx_hi; // rx_* hold the last frame's reply
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp; // resp: last bus response
  logic [15:0] range_prot, sector_prot;
  int err_count, check_count;
  spi_link_if link();
  flash_prot_host u_flash_prot_host (.clk(clk), .sys_rst(sys_rst), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(link.host));
  flash_prot_dev u_flash_prot_dev (.clk(clk), .sys_rst(sys_rst), .ce(ce), .link(link.device),
    .range_prot(range_prot), .sector_prot(sector_prot), .key_mode(key_mode),
    .persist_mode(persist_mode));
  prot_checker u_prot_checker (.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
  // 100 mhz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ----
  // bus and frame tasks
  // ----
  task automatic conclude;
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one edge of a bounded wait; running out counts as a mismatch
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 3000) begin
      err_count++;
      conclude;
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
  // one device frame, polled until idle; an unknown busy keeps polling
  task automatic cmd(input logic [7:0] op, input logic [3:0] len, input logic [31:0] lo, hi);
    int n;
    n = 0;
    wr(ADDR_TX_LO, lo);
    wr(ADDR_TX_HI, hi);
    wr(ADDR_CTRL, {1'h1, 19'h0_0000, len, op});
    do begin
      tick(n);
      rd(ADDR_STAT, rx_lo);
    end while (rx_lo[0] !== 1'h0);
    rd(ADDR_RX_LO, rx_lo);
    rd(ADDR_RX_HI, rx_hi);
  endtask
  task automatic rst;
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {ce, sys_rst, awvalid, wvalid, bready, arvalid, rready} = 7'h60;
    {awaddr, araddr, wdata, range_prot} = '0;
    wstrb = 4'hF;
    err_count = 0;
    check_count = 0;
    rst;
    rd(5'h18, rx_lo);
    `CHK(resp, RESP_SLVERR)
    wr(5'h1C, 32'h0000_0000);
    `CHK(resp, RESP_SLVERR)
    // only the two middle byte lanes may land
    wstrb <= 4'h6;
    wr(ADDR_TX_LO, 32'h1234_5678);
    wstrb <= 4'hF;
    rd(ADDR_TX_LO, rx_lo);
    `CHK(rx_lo, 32'h0034_5600)
    cmd(OP_RD_CFG, 4'h2, 32'h0, 32'h0);
    `CHK(rx_lo[15:0], CFG_DELIVERY)
    cmd(OP_RD_LOCK, 4'h1, 32'h0, 32'h0);
    `CHK(rx_lo[7:0], 8'h01)
    cmd(OP_PROG_NV, 4'h1, 32'h3, 32'h0);
    cmd(OP_RD_NV, 4'h2, 32'h3, 32'h0);
    `CHK(rx_lo[7:0], BIT_OPEN)
    cmd(OP_LATCH, 4'h0, 32'h0, 32'h0);
    cmd(OP_PROG_NV, 4'h1, 32'h3, 32'h0);
    cmd(OP_RD_NV, 4'h2, 32'h3, 32'h0);
    `CHK(rx_lo[7:0], BIT_PROT)
    cmd(OP_WR_VOL, 4'h2, 32'h0005, 32'h0);
    cmd(OP_RD_VOL, 4'h2, 32'h5, 32'h0);
    `CHK(rx_lo[7:0], BIT_PROT)
    `CHK(sector_prot, 16'h0028)
    cmd(OP_WR_VOL, 4'h2, 32'hFF05, 32'h0);
    range_prot <= 16'h0080;
    cmd(OP_RD_VOL, 4'h2, 32'h5, 32'h0);
    `CHK(rx_lo[7:0], BIT_OPEN)
    `CHK(sector_prot, 16'h0088)
    cmd(OP_WR_LOCK, 4'h1, 32'h0, 32'h0);
    cmd(OP_RD_LOCK, 4'h1, 32'h0, 32'h0);
    `CHK(rx_lo[7:0], 8'h00)
    cmd(OP_LATCH, 4'h0, 32'h0, 32'h0);
    cmd(OP_PROG_NV, 4'h1, 32'h4, 32'h0);
    cmd(OP_RD_NV, 4'h2, 32'h4, 32'h0);
    `CHK(rx_lo[7:0], BIT_OPEN)
    cmd(OP_RD_KEY, 4'h8, 32'h0, 32'h0);
    `CHK({rx_hi, rx_lo}, KEY_DELIVERY)
    cmd(OP_LATCH, 4'h0, 32'h0, 32'h0);
    cmd(OP_PROG_KEY, 4'h8, 32'h4433_2211, 32'h8877_6655);
    cmd(OP_LATCH, 4'h0, 32'h0, 32'h0);
    cmd(OP_PROG_KEY, 4'h8, 32'hFFFF_FF00, 32'hFFFF_FFFF);
    cmd(OP_RD_KEY, 4'h8, 32'h0, 32'h0);
    `CHK({rx_hi, rx_lo}, 64'h0022_3344_5566_7788)
    cmd(OP_LATCH, 4'h0, 32'h0, 32'h0);
    cmd(OP_PROG_CFG, 4'h2, 32'hFFFB, 32'h0);
    cmd(OP_LATCH, 4'h0, 32'h0, 32'h0);
    cmd(OP_PROG_CFG, 4'h2, 32'hFFFF, 32'h0);
    cmd(OP_RD_CFG, 4'h2, 32'h0, 32'h0);
    `CHK(rx_lo[15:0], 16'hFBFF)
    `CHK({key_mode, persist_mode}, 2'h2)
    cmd(OP_RD_KEY, 4'h8, 32'h0, 32'h0);
    `CHK({rx_hi, rx_lo}, {8{KEY_HIDDEN}})
    rst;
    `CHK(sector_prot, 16'h0080)
    cmd(OP_LATCH, 4'h0, 32'h0, 32'h0);
    cmd(OP_PROG_CFG, 4'h2, 32'hFFFD, 32'h0);
    `CHK({key_mode, persist_mode}, 2'h1)
    conclude;
  end
endmodule

/* spi_link_if.sv */
`timescale 1ns/100ps
// four-wire serial link between controller and flash
interface spi_link_if;
  logic sclk; // serial clock, made by the host
  logic cs_n; // frame select, low active
  logic mosi; // host to device data
  logic miso; // device to host data
  modport host(output sclk, output cs_n, output mosi, input miso);
  modport device(input sclk, input cs_n, input mosi, output miso);
endinterface
